// >>> core/flash_self_program_pkg.sv
// Constants, commands and state codes of the flash self-programming block
package flash_self_program_pkg;
    // Clock and programming time
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_TIME_MIN_NS = 3_700_000;
    localparam int PROG_TIME_MAX_NS = 4_500_000;
    localparam int PROG_MIN_CYCLES =
        (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYCLES = PROG_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int OP_CNT_W = 17;
    // Arming windows after a control write
    localparam int ARM_STORE_CYCLES = 4;
    localparam int ARM_LOAD_CYCLES = 3;
    localparam logic [2:0] ARM_STORE_CNT = 3'(ARM_STORE_CYCLES);
    localparam logic [2:0] LOAD_MIN_CNT =
        3'(ARM_STORE_CYCLES - ARM_LOAD_CYCLES + 1);
    localparam logic [2:0] ARM_LAST_CNT = 3'h1;
    // Control register layout
    localparam int CTRL_CMD_W = 5;
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_RWW_BUSY_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Command combinations of the low five control bits
    localparam logic [4:0] CMD_NONE = 5'h00;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_RWW = 5'h11;
    // Pointer values of the fuse and lock reads
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [5:0] LOCK_RSVD_FILL = 6'h3F;
    // Page buffer
    localparam int PAGE_WORDS_DEF = 32;
    localparam logic [15:0] BUF_ERASED = 16'hFFFF;
    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ARMED = 3'h2,
        ST_BUSY = 3'h4
    } state_t;
endpackage

// >>> core/flash_self_program_ctrl.sv
// Flash self-programming controller: arming, page buffer, fuse reads
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_ctrl #(
    parameter int PAGE_WORDS = flash_self_program_pkg::PAGE_WORDS_DEF,
    parameter int PROG_CYCLES = flash_self_program_pkg::PROG_MIN_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control register write and readback
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl_rdata_q,
    // CPU instruction strobes and operands
    input wire logic store_op,
    input wire logic load_op,
    input wire logic [15:0] pointer,
    input wire logic [15:0] data_word_pair,
    input wire logic global_irq_enable,
    // CPU results
    output logic load_special_q,
    output logic [7:0] load_data_q,
    output logic cpu_stall_q,
    output logic ready_irq_q,
    // EEPROM status
    input wire logic eeprom_write_busy,
    input wire logic eeprom_write_start,
    // Fuse and lock cells, one means programmed
    input wire logic [7:0] fuse_low_prog,
    input wire logic [7:0] fuse_high_prog,
    input wire logic [7:0] fuse_ext_prog,
    input wire logic [1:0] lock_prog,
    // Flash array side
    output logic flash_erase_go_q,
    output logic flash_write_go_q,
    output logic lock_write_go_q,
    output logic [14-$clog2(PAGE_WORDS):0] flash_page_q,
    output logic [7:0] lock_wr_data_q,
    output logic [16*PAGE_WORDS-1:0] page_buf_flat
);
    localparam int WB = $clog2(PAGE_WORDS);
    localparam logic [flash_self_program_pkg::OP_CNT_W-1:0] OP_LAST =
        flash_self_program_pkg::OP_CNT_W'(PROG_CYCLES - 1);

    flash_self_program_pkg::state_t state_q;
    logic [4:0] cmd_q;
    logic [2:0] arm_cnt_q;
    logic irq_en_q;
    logic [flash_self_program_pkg::OP_CNT_W-1:0] op_cnt_q;
    logic [15:0] buf_q [PAGE_WORDS];
    logic loaded_any_q;
    logic cmd_valid;
    logic wr_accept;
    logic store_hit;
    logic read_hit;
    logic timed_cmd;
    logic start_op;
    logic op_done;
    logic buf_load;
    logic buf_clear;
    logic [WB-1:0] word_idx;
    logic busy;
    logic armed;

    // Command decode and acceptance terms
    assign busy = state_q == flash_self_program_pkg::ST_BUSY;
    assign armed = state_q == flash_self_program_pkg::ST_ARMED;
    assign cmd_valid = ctrl_wdata[4:0] == flash_self_program_pkg::CMD_LOAD
        || ctrl_wdata[4:0] == flash_self_program_pkg::CMD_ERASE
        || ctrl_wdata[4:0] == flash_self_program_pkg::CMD_WRITE
        || ctrl_wdata[4:0] == flash_self_program_pkg::CMD_LOCK
        || ctrl_wdata[4:0] == flash_self_program_pkg::CMD_RWW;
    assign wr_accept = ctrl_wr && !eeprom_write_busy && !busy
        && !reset;
    assign store_hit = armed && store_op && !eeprom_write_busy
        && !reset;
    assign read_hit = armed && load_op && !eeprom_write_busy && !reset
        && cmd_q == flash_self_program_pkg::CMD_LOCK
        && arm_cnt_q >= flash_self_program_pkg::LOAD_MIN_CNT
        && pointer[15:2] == 14'h0000;
    assign timed_cmd = cmd_q == flash_self_program_pkg::CMD_ERASE
        || cmd_q == flash_self_program_pkg::CMD_WRITE
        || cmd_q == flash_self_program_pkg::CMD_LOCK;
    assign start_op = store_hit && timed_cmd;
    assign op_done = busy && op_cnt_q == '0;
    // Word within page from low pointer bits, bit zero ignored
    assign word_idx = pointer[WB:1];
    assign buf_load = store_hit
        && cmd_q == flash_self_program_pkg::CMD_LOAD;
    assign buf_clear = reset
        || (op_done && cmd_q == flash_self_program_pkg::CMD_WRITE)
        || (wr_accept
            && ctrl_wdata[4:0] == flash_self_program_pkg::CMD_RWW)
        || (eeprom_write_start && loaded_any_q);

    // Sequencer: arming window, command hold, busy; busy ignores reset
    always_ff @(posedge ref_clk) begin
        case (state_q)
            flash_self_program_pkg::ST_BUSY: begin
                if (op_done) begin
                    state_q <= flash_self_program_pkg::ST_IDLE;
                    cmd_q <= flash_self_program_pkg::CMD_NONE;
                end
            end
            flash_self_program_pkg::ST_IDLE,
            flash_self_program_pkg::ST_ARMED: begin
                if (reset) begin
                    state_q <= flash_self_program_pkg::ST_IDLE;
                    cmd_q <= flash_self_program_pkg::CMD_NONE;
                    arm_cnt_q <= 3'h0;
                end else if (wr_accept && cmd_valid) begin
                    state_q <= flash_self_program_pkg::ST_ARMED;
                    cmd_q <= ctrl_wdata[4:0];
                    arm_cnt_q <= flash_self_program_pkg::ARM_STORE_CNT;
                end else if (start_op) begin
                    state_q <= flash_self_program_pkg::ST_BUSY;
                    arm_cnt_q <= 3'h0;
                end else if (armed && (store_hit || read_hit
                    || arm_cnt_q == flash_self_program_pkg::ARM_LAST_CNT))
                begin
                    state_q <= flash_self_program_pkg::ST_IDLE;
                    cmd_q <= flash_self_program_pkg::CMD_NONE;
                    arm_cnt_q <= 3'h0;
                end else if (armed) begin
                    arm_cnt_q <= arm_cnt_q - 3'h1;
                end
            end
            default: begin
                state_q <= flash_self_program_pkg::ST_IDLE;
                cmd_q <= flash_self_program_pkg::CMD_NONE;
                arm_cnt_q <= 3'h0;
            end
        endcase
    end

    // Programming timer, runs through a reset once started
    always_ff @(posedge ref_clk) begin
        if (busy) begin
            if (op_cnt_q != '0) begin
                op_cnt_q <= op_cnt_q - 1'b1;
            end
        end else if (start_op) begin
            op_cnt_q <= OP_LAST;
        end else begin
            op_cnt_q <= '0;
        end
    end

    // CPU stall from the store that starts a timed operation to its end
    always_ff @(posedge ref_clk) begin
        cpu_stall_q <= start_op || (busy && !op_done);
    end

    // Temporary page buffer, one word of flip-flops per slot
    genvar g;
    for (g = 0; g < PAGE_WORDS; g++) begin : g_buf
        always_ff @(posedge ref_clk) begin
            if (buf_clear) begin
                buf_q[g] <= flash_self_program_pkg::BUF_ERASED;
            end else if (buf_load && word_idx == WB'(g)) begin
                buf_q[g] <= data_word_pair;
            end
        end
        assign page_buf_flat[16*g +: 16] = buf_q[g];
    end

    // Tracks whether any word has been loaded since the last clear
    always_ff @(posedge ref_clk) begin
        if (buf_clear) begin
            loaded_any_q <= 1'b0;
        end else if (buf_load) begin
            loaded_any_q <= 1'b1;
        end
    end

    // Fuse and lock read results, cell state inverted
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            load_special_q <= 1'b0;
            load_data_q <= 8'h00;
        end else begin
            load_special_q <= read_hit;
            if (read_hit) begin
                case (pointer)
                    flash_self_program_pkg::PTR_FUSE_LOW:
                        load_data_q <= ~fuse_low_prog;
                    flash_self_program_pkg::PTR_FUSE_EXT:
                        load_data_q <= ~fuse_ext_prog;
                    flash_self_program_pkg::PTR_FUSE_HIGH:
                        load_data_q <= ~fuse_high_prog;
                    default:
                        load_data_q <= {flash_self_program_pkg::LOCK_RSVD_FILL,
                            ~lock_prog};
                endcase
            end
        end
    end

    // Start strobes and latched page toward the flash array
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flash_erase_go_q <= 1'b0;
            flash_write_go_q <= 1'b0;
            lock_write_go_q <= 1'b0;
        end else begin
            flash_erase_go_q <= start_op
                && cmd_q == flash_self_program_pkg::CMD_ERASE;
            flash_write_go_q <= start_op
                && cmd_q == flash_self_program_pkg::CMD_WRITE;
            lock_write_go_q <= start_op
                && cmd_q == flash_self_program_pkg::CMD_LOCK;
        end
        if (reset && !busy) begin
            flash_page_q <= '0;
            lock_wr_data_q <= 8'h00;
        end else if (start_op) begin
            flash_page_q <= pointer[15:WB+1];
            lock_wr_data_q <= data_word_pair[7:0];
        end
    end

    // Interrupt enable, readback and ready interrupt
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_en_q <= 1'b0;
            ctrl_rdata_q <= flash_self_program_pkg::CTRL_RESET;
            ready_irq_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                irq_en_q <=
                    ctrl_wdata[flash_self_program_pkg::CTRL_IRQ_EN_BIT];
            end
            ctrl_rdata_q <= {irq_en_q, 1'b0, 1'b0, cmd_q};
            ready_irq_q <= irq_en_q && global_irq_enable && !cmd_q[0]
                && !busy && !eeprom_write_busy;
        end
    end

    // Checks of the sequencing and result behaviour
    AST_LOAD_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        buf_load && !buf_clear |=>
        buf_q[$past(word_idx)] == $past(data_word_pair))
        else $error("page buffer word not stored");
    AST_ARM_TIMEOUT: assert property (
        @(posedge ref_clk) disable iff (reset)
        (wr_accept && cmd_valid) ##1
        (!store_op && !load_op && !ctrl_wr)[*4] |=>
        state_q == flash_self_program_pkg::ST_IDLE && cmd_q == 5'h00)
        else $error("arming window did not expire after four cycles");
    AST_STALL_HOLD: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(cpu_stall_q) |-> cpu_stall_q[*8])
        else $error("cpu stall dropped early");
    AST_OP_LEN: assert property (
        @(posedge ref_clk) disable iff (reset)
        (flash_write_go_q || flash_erase_go_q || lock_write_go_q) |->
        op_cnt_q == OP_LAST && cpu_stall_q)
        else $error("programming timer not loaded with full time");
    AST_OP_END: assert property (
        @(posedge ref_clk) disable iff (reset)
        op_done |=> !cpu_stall_q && !cmd_q[0])
        else $error("stall or enable held after operation end");
    AST_WRITE_CLR: assert property (
        @(posedge ref_clk) disable iff (reset)
        op_done && cmd_q == flash_self_program_pkg::CMD_WRITE |=>
        !loaded_any_q && buf_q[0] == 16'hFFFF)
        else $error("buffer not cleared after page write");
    AST_EE_DISCARD: assert property (
        @(posedge ref_clk) disable iff (reset)
        eeprom_write_start && loaded_any_q |=> !loaded_any_q)
        else $error("buffer kept across eeprom write start");
    AST_EE_BLOCK: assert property (
        @(posedge ref_clk) disable iff (reset)
        eeprom_write_busy && state_q == flash_self_program_pkg::ST_IDLE
        |=> state_q == flash_self_program_pkg::ST_IDLE)
        else $error("command accepted during eeprom write");
    AST_BAD_CMD: assert property (
        @(posedge ref_clk) disable iff (reset)
        ctrl_wr && !cmd_valid
        && state_q == flash_self_program_pkg::ST_IDLE
        |=> state_q == flash_self_program_pkg::ST_IDLE)
        else $error("undefined command started an operation");
    AST_FUSE_LOW: assert property (
        @(posedge ref_clk) disable iff (reset)
        read_hit && pointer == 16'h0000 |=> load_special_q
        && load_data_q == ~$past(fuse_low_prog))
        else $error("fuse low byte read wrong");
    AST_FUSE_HIGH: assert property (
        @(posedge ref_clk) disable iff (reset)
        read_hit && pointer == flash_self_program_pkg::PTR_FUSE_HIGH |=>
        load_special_q && load_data_q == ~$past(fuse_high_prog))
        else $error("fuse high byte read wrong");
    AST_FUSE_EXT: assert property (
        @(posedge ref_clk) disable iff (reset)
        read_hit && pointer == flash_self_program_pkg::PTR_FUSE_EXT |=>
        load_special_q && load_data_q == ~$past(fuse_ext_prog))
        else $error("fuse extended byte read wrong");
    AST_LOCK_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        read_hit && pointer == flash_self_program_pkg::PTR_LOCK |=>
        load_special_q && !cmd_q[0] && load_data_q
        == {flash_self_program_pkg::LOCK_RSVD_FILL, ~$past(lock_prog)})
        else $error("lock bits read wrong or read mode kept");
    AST_LOAD_LATE: assert property (
        @(posedge ref_clk) disable iff (reset)
        armed && load_op && arm_cnt_q == flash_self_program_pkg::ARM_LAST_CNT
        |=> !load_special_q)
        else $error("load answered after the three cycle window");
    AST_RWW_CLEAR: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_accept && ctrl_wdata[4:0] == flash_self_program_pkg::CMD_RWW |=>
        !loaded_any_q
        && buf_q[0] == flash_self_program_pkg::BUF_ERASED)
        else $error("buffer kept across rww read enable write");
    AST_PAGE_LATCH: assert property (
        @(posedge ref_clk) disable iff (reset)
        start_op |=> flash_page_q == $past(pointer[15:WB+1]))
        else $error("page number not latched at operation start");
    AST_RWW_ZERO: assert property (
        @(posedge ref_clk) disable iff (reset)
        ##1 ctrl_rdata_q[6] == 1'b0)
        else $error("rww busy flag read as one");
    AST_IRQ_QUIET: assert property (
        @(posedge ref_clk) disable iff (reset)
        busy || cmd_q[0] |=> !ready_irq_q)
        else $error("ready interrupt while programming");
    AST_RESET_KEEP: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        reset && busy && op_cnt_q > 1 |=> busy)
        else $error("reset aborted a write in progress");
endmodule
`default_nettype wire

// >>> verif/cpu_prog_model.sv
// Processor model issuing control writes, store and load strobes
`timescale 1ns/10ps
`default_nettype none
module cpu_prog_model (
    // Clock and core status
    input wire logic ref_clk,
    input wire logic cpu_stall_q,
    input wire logic eeprom_write_busy,
    // Instruction strobes and operands
    output logic ctrl_wr,
    output logic [7:0] ctrl_wdata,
    output logic store_op,
    output logic load_op,
    output logic [15:0] pointer,
    output logic [15:0] data_word_pair
);
    // Idle strobes at time zero
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        store_op = 1'b0;
        load_op = 1'b0;
        pointer = 16'h0000;
        data_word_pair = 16'h0000;
    end
    // Control write after stall and optional EEPROM busy poll
    task automatic ctrl(input logic [7:0] v, input bit poll);
        int n;
        n = 0;
        while ((cpu_stall_q === 1'b1 || (poll && eeprom_write_busy !== 1'b0))
            && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 200) tb_flash_self_program_ctrl.fail_wait();
        @(posedge ref_clk);
        #1;
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(posedge ref_clk);
        #1;
        ctrl_wr = 1'b0;
    endtask
    // One store or load strobe after gap idle cycles
    task automatic op(input bit ld, input int gap, input logic [15:0] p,
        input logic [15:0] d);
        repeat (gap) begin
            @(posedge ref_clk);
            #1;
        end
        pointer = p;
        data_word_pair = d;
        store_op = !ld;
        load_op = ld;
        @(posedge ref_clk);
        #1;
        store_op = 1'b0;
        load_op = 1'b0;
        pointer = ~p; // Stale operands do not linger
        data_word_pair = ~d;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_flash_self_program_ctrl.sv
// Self-checking bench of the flash self-programming controller
`timescale 1ns/10ps
`default_nettype none
module tb_flash_self_program_ctrl;
    localparam int PW = 4;
    localparam int PC = 20;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic ctrl_wr, store_op, load_op, ld_sp, stall, irq, egs, wgs, lgs;
    logic [7:0] ctrl_wdata, rdata, ldata, lwd;
    logic [15:0] pointer, data_word_pair;
    logic [12:0] fpage;
    logic [16*PW-1:0] buf_flat;
    logic gie = 1'b0;
    logic ee_busy = 1'b0;
    logic ee_start = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    always #50 ref_clk = ~ref_clk;
    // Device and processor model
    flash_self_program_ctrl #(.PAGE_WORDS(PW), .PROG_CYCLES(PC)) uut (
        .ref_clk(ref_clk), .reset(reset), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata_q(rdata), .store_op(store_op),
        .load_op(load_op), .pointer(pointer), .data_word_pair(data_word_pair),
        .global_irq_enable(gie), .load_special_q(ld_sp), .load_data_q(ldata),
        .cpu_stall_q(stall), .ready_irq_q(irq), .eeprom_write_busy(ee_busy),
        .eeprom_write_start(ee_start), .fuse_low_prog(8'h3C),
        .fuse_high_prog(8'hA5), .fuse_ext_prog(8'h0F), .lock_prog(2'h1),
        .flash_erase_go_q(egs), .flash_write_go_q(wgs),
        .lock_write_go_q(lgs), .flash_page_q(fpage), .lock_wr_data_q(lwd),
        .page_buf_flat(buf_flat));
    cpu_prog_model cpu (.ref_clk(ref_clk), .cpu_stall_q(stall),
        .eeprom_write_busy(ee_busy), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .store_op(store_op), .load_op(load_op),
        .pointer(pointer), .data_word_pair(data_word_pair));
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic fail_wait();
        fail_count++;
        print_verdict();
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // Wait up to four cycles for flag k: erase, write, lock, special
    task automatic wait_flag(input int k);
        logic [3:0] f;
        int n;
        for (n = 0; n < 4; n++) begin
            f = {ld_sp, lgs, wgs, egs};
            if (f[k] === 1'b1) break;
            tick(1);
        end
        if (n == 4) fail_wait();
    endtask
    task automatic stall_len(output int n);
        n = 0;
        while (stall === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        if (n >= 100) fail_wait();
    endtask
    task automatic t_fill_write();
        int n;
        for (int g = 0; g < PW; g++) begin
            cpu.ctrl(8'h01, 1'b1);
            cpu.op(1'b0, 0, 16'h0028 | 16'(g << 1), 16'hA000 + 16'(g));
        end
        tick(1);
        check(buf_flat, 64'hA003A002A001A000);
        cpu.ctrl(8'h05, 1'b1);
        cpu.op(1'b0, 0, 16'h0028, 16'h1234);
        wait_flag(1);
        check(64'(fpage), 64'h5);
        tick(2);
        check(64'(rdata), 64'h5);
        stall_len(n);
        check(64'(n), 64'(PC - 2));
        tick(1);
        check(64'(rdata), 64'h0);
        check(buf_flat, {PW{16'hFFFF}});
        $display("done: fill and write");
    endtask
    task automatic t_erase_reset();
        int n;
        cpu.ctrl(8'h03, 1'b1);
        cpu.op(1'b0, 0, 16'h0050, 16'h0000);
        wait_flag(0);
        tick(1);
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        check(64'(stall), 64'h1);
        check(64'(fpage), 64'hA);
        stall_len(n);
        check(64'(n), 64'(PC - 3));
        $display("done: erase with reset");
    endtask
    task automatic t_fuse();
        logic [7:0] exp [4] = '{8'hC3, 8'hFE, 8'hF0, 8'h5A};
        int n;
        for (int p = 0; p < 4; p++) begin
            cpu.ctrl(8'h09, 1'b1);
            cpu.op(1'b1, (p == 3) ? 2 : 0, 16'(p), 16'h0000);
            wait_flag(3);
            check(64'(ldata), 64'(exp[p]));
        end
        cpu.ctrl(8'h09, 1'b1);
        cpu.op(1'b1, 3, 16'h0000, 16'h0000);
        check(64'(ld_sp), 64'h0);
        tick(2);
        check(64'({ld_sp, rdata}), 64'h0);
        cpu.ctrl(8'h09, 1'b1);
        cpu.op(1'b0, 3, 16'h0000, 16'h00C3);
        wait_flag(2);
        check(64'(lwd), 64'hC3);
        stall_len(n);
        check(64'(n), 64'(PC));
        $display("done: fuse and lock");
    endtask
    task automatic t_eeprom();
        cpu.ctrl(8'h01, 1'b1);
        cpu.op(1'b0, 0, 16'h0000, 16'h1111);
        ee_start = 1'b1;
        tick(1);
        ee_start = 1'b0;
        tick(1);
        check(buf_flat, {PW{16'hFFFF}});
        ee_busy = 1'b1;
        cpu.ctrl(8'h01, 1'b0);
        cpu.op(1'b0, 0, 16'h0002, 16'h2222);
        cpu.ctrl(8'h09, 1'b0);
        cpu.op(1'b1, 0, 16'h0000, 16'h0000);
        tick(1);
        check(64'({ld_sp, rdata}), 64'h0);
        check(buf_flat, {PW{16'hFFFF}});
        ee_busy = 1'b0;
        cpu.ctrl(8'h01, 1'b1);
        cpu.op(1'b0, 0, 16'h0004, 16'h3333);
        check(buf_flat, 64'hFFFF3333FFFFFFFF);
        cpu.ctrl(8'h11, 1'b1);
        tick(1);
        check(buf_flat, {PW{16'hFFFF}});
        $display("done: eeprom and buffer clear");
    endtask
    task automatic t_bad_irq();
        gie = 1'b1;
        tick(4);
        cpu.ctrl(8'h87, 1'b1);
        cpu.op(1'b0, 0, 16'h0000, 16'h4444);
        tick(2);
        check(buf_flat, {PW{16'hFFFF}});
        check(64'({rdata, irq}), 64'h101);
        cpu.ctrl(8'h81, 1'b1);
        tick(1);
        check(64'(irq), 64'h0);
        cpu.op(1'b0, 3, 16'h0006, 16'h5555);
        tick(2);
        check(buf_flat, {PW{16'hFFFF}});
        check(64'(rdata), 64'h80);
        $display("done: ignored command and irq");
    endtask
    initial begin
        tick(16);
        reset = 1'b0;
        check(buf_flat, {PW{16'hFFFF}});
        check(64'({rdata, stall}), 64'h0);
        t_fill_write();
        t_erase_reset();
        t_fuse();
        t_eeprom();
        t_bad_irq();
        print_verdict();
    end
endmodule
`default_nettype wire
